//--- core/pia_defines.svh
// register offsets, field positions, reset values and fixed source masks
`ifndef PIA_DEFINES_SVH
`define PIA_DEFINES_SVH

// register offsets; group g flags/block/live sit at base + stride*g
`define PIA_OFS_FLAGS 8'h00
`define PIA_OFS_BLOCK 8'h01
`define PIA_OFS_LIVE 8'h02
`define PIA_GRP_STRIDE 8'h03
`define PIA_OFS_EDGE_RISE 8'h0C
`define PIA_OFS_EDGE_FALL 8'h0D
`define PIA_OFS_IRQ_CTRL 8'h0E
`define PIA_OFS_OSC_THERMAL_CFG 8'h0F

// irq_ctrl fields
`define PIA_CTRL_CLR_WR 0
`define PIA_CTRL_PEND_EN 1
`define PIA_CTRL_POL_HI 2
// osc_thermal_cfg_reg field
`define PIA_CFG_MASK_SLEEP 0

// reset values
`define PIA_CTRL_RST 8'h02
`define PIA_CFG_RST 8'h00
`define PIA_BLOCK_RST 8'h00
`define PIA_EDGE_RST 8'h00
`define PIA_UNMAPPED 8'hFF

// fixed edge sensitivity of groups 1..3
`define PIA_G1_RISE 8'h70
`define PIA_G1_FALL 8'h7E
`define PIA_G2_RISE 8'h57
`define PIA_G2_FALL 8'h00
`define PIA_G3_RISE 8'h87
`define PIA_G3_FALL 8'h80

// group 1 sources silenced in OFF: overtemp, remote power-on, key
`define PIA_G1_OFF_GATE 8'h2A
// group 1 sources that wake regardless of block
`define PIA_G1_WAKE_ANY 8'h0A
// wake sources that need their block bit clear
`define PIA_G2_WAKE 8'h43
`define PIA_G3_WAKE 8'h87
`define PIA_G4_WAKE 8'hFF

// cycles after reset before edges are believed
`define PIA_ARM_CYC 2'd3

`endif

//--- core/pia_pkg.sv
// types shared by the interrupt aggregator
package pia_pkg;

  typedef enum logic [1:0] {
    PIA_OFF    = 2'b00,
    PIA_ACTIVE = 2'b01,
    PIA_SLEEP  = 2'b10
  } pia_pwr_type;

  typedef logic [3:0][7:0] pia_grp_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pia_req_type;

  typedef struct packed {
    pia_grp_type sync1;
    pia_grp_type sync2;
    pia_grp_type sync3;
    pia_grp_type filt;
    pia_grp_type flags;
    pia_grp_type pend;
    pia_grp_type block;
    logic [7:0] edge_rise;
    logic [7:0] edge_fall;
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] last_addr;
    logic last_vld;
    logic [1:0] arm_cnt;
    logic [7:0] rdata;
    logic irq_line;
    logic on_req;
    logic sleep_hold;
  } pia_state_type;

endpackage : pia_pkg

//--- core/pia_top.sv
// interrupt aggregator: four groups of flags, blocks and live levels
`timescale 1ns/1ps
`include "pia_defines.svh"

module pia_top (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire pia_pkg::pia_grp_type i_src_line,
  input wire pia_pkg::pia_pwr_type i_pwr_state,
  input wire pia_pkg::pia_req_type i_req,
  output logic [7:0] o_rdata,
  output logic o_irq_line,
  output logic o_on_req,
  output logic o_sleep_hold
);
  import pia_pkg::*;

  localparam pia_grp_type RISE_FIX = {
    8'h00, `PIA_G3_RISE, `PIA_G2_RISE, `PIA_G1_RISE
  };
  localparam pia_grp_type FALL_FIX = {
    8'h00, `PIA_G3_FALL, `PIA_G2_FALL, `PIA_G1_FALL
  };
  localparam pia_grp_type OFF_GATE = {
    8'h00, 8'h00, 8'h00, `PIA_G1_OFF_GATE
  };
  localparam pia_grp_type WAKE_ANY = {
    8'h00, 8'h00, 8'h00, `PIA_G1_WAKE_ANY
  };
  localparam pia_grp_type WAKE_UNM = {
    `PIA_G4_WAKE, `PIA_G3_WAKE, `PIA_G2_WAKE, 8'h00
  };
  localparam pia_state_type RST_STATE = '{
    block: {4{`PIA_BLOCK_RST}},
    edge_rise: `PIA_EDGE_RST,
    edge_fall: `PIA_EDGE_RST,
    ctrl: `PIA_CTRL_RST,
    cfg: `PIA_CFG_RST,
    rdata: `PIA_UNMAPPED,
    irq_line: 1'b1,
    default: '0
  };

  pia_state_type q_r;
  pia_state_type q_nxt;
  pia_grp_type rise_en;
  pia_grp_type fall_en;
  pia_grp_type edge_ev;
  pia_grp_type evt;
  pia_grp_type clr;
  pia_grp_type clr_eff;
  pia_grp_type rep_ev;
  pia_grp_type pend_rel;
  logic armed;
  logic off_state;
  logic acc;
  logic same;
  logic wake_pulse;
  logic any_flag;
  logic line_on;
  logic [7:0] stab;
  logic [7:0] chg;
  logic [7:0] ofs;

  always_comb begin
    q_nxt = q_r;
    stab = '0;
    chg = '0;
    ofs = '0;
    q_nxt.sync1 = i_src_line;
    q_nxt.sync2 = q_r.sync1;
    q_nxt.sync3 = q_r.sync2;
    armed = (q_r.arm_cnt == `PIA_ARM_CYC);
    if (!armed) begin
      q_nxt.arm_cnt = q_r.arm_cnt + 2'd1;
    end
    rise_en = RISE_FIX;
    fall_en = FALL_FIX;
    rise_en[3] = q_r.edge_rise;
    fall_en[3] = q_r.edge_fall;
    off_state = (i_pwr_state != PIA_ACTIVE) &&
                (i_pwr_state != PIA_SLEEP);
    acc = i_req.rd | i_req.wr;
    same = q_r.last_vld && (q_r.last_addr == i_req.addr);
    for (int g = 0; g < 4; g++) begin
      // a change counts once the last two stages agree
      stab = ~(q_r.sync2[g] ^ q_r.sync3[g]);
      chg = stab & (q_r.sync3[g] ^ q_r.filt[g]);
      // preload until armed so no false edge follows reset
      q_nxt.filt[g] = armed ?
                      ((q_r.filt[g] & ~stab) | (q_r.sync3[g] & stab)) :
                      q_r.sync2[g];
      edge_ev[g] = armed ? ((chg & q_r.sync3[g] & rise_en[g]) |
                            (chg & ~q_r.sync3[g] & fall_en[g])) :
                           8'h00;
      evt[g] = edge_ev[g] & ~q_r.block[g] &
               ~(off_state ? OFF_GATE[g] : 8'h00);
      ofs = `PIA_OFS_FLAGS + `PIA_GRP_STRIDE * 8'(g);
      clr[g] = 8'h00;
      if (acc && !same && i_req.addr == ofs) begin
        if (i_req.rd && !q_r.ctrl[`PIA_CTRL_CLR_WR]) begin
          clr[g] = 8'hFF;
        end else if (i_req.wr && q_r.ctrl[`PIA_CTRL_CLR_WR]) begin
          clr[g] = i_req.wdata;
        end
      end
      clr_eff[g] = clr[g] & q_r.flags[g];
      rep_ev[g] = evt[g] & q_r.flags[g] & ~clr_eff[g];
      pend_rel[g] = clr_eff[g] & q_r.pend[g];
      // an arriving event always beats a clear
      q_nxt.flags[g] = (q_r.flags[g] & ~clr_eff[g]) | pend_rel[g] |
                       evt[g];
      if (q_r.ctrl[`PIA_CTRL_PEND_EN]) begin
        q_nxt.pend[g] = (q_r.pend[g] & ~clr_eff[g]) | rep_ev[g] |
                        (evt[g] & pend_rel[g]);
      end else begin
        q_nxt.pend[g] = 8'h00;
      end
    end
    wake_pulse = 1'b0;
    for (int g = 0; g < 4; g++) begin
      wake_pulse = wake_pulse | (|(edge_ev[g] & WAKE_ANY[g])) |
                   (|(evt[g] & WAKE_UNM[g]));
    end
    // register writes and reads
    q_nxt.rdata = `PIA_UNMAPPED;
    if (acc) begin
      q_nxt.last_addr = i_req.addr;
      q_nxt.last_vld = 1'b1;
    end
    for (int g = 0; g < 4; g++) begin
      ofs = `PIA_GRP_STRIDE * 8'(g);
      if (i_req.wr && i_req.addr == `PIA_OFS_BLOCK + ofs) begin
        q_nxt.block[g] = i_req.wdata;
      end
      if (i_req.rd && i_req.addr == `PIA_OFS_FLAGS + ofs) begin
        q_nxt.rdata = q_r.flags[g];
      end
      if (i_req.rd && i_req.addr == `PIA_OFS_BLOCK + ofs) begin
        q_nxt.rdata = q_r.block[g];
      end
      if (i_req.rd && i_req.addr == `PIA_OFS_LIVE + ofs) begin
        q_nxt.rdata = q_r.filt[g];
      end
    end
    if (i_req.wr) begin
      if (i_req.addr == `PIA_OFS_EDGE_RISE) begin
        q_nxt.edge_rise = i_req.wdata;
      end
      if (i_req.addr == `PIA_OFS_EDGE_FALL) begin
        q_nxt.edge_fall = i_req.wdata;
      end
      if (i_req.addr == `PIA_OFS_IRQ_CTRL) begin
        q_nxt.ctrl = i_req.wdata;
      end
      if (i_req.addr == `PIA_OFS_OSC_THERMAL_CFG) begin
        q_nxt.cfg = i_req.wdata;
      end
    end
    if (i_req.rd) begin
      if (i_req.addr == `PIA_OFS_EDGE_RISE) begin
        q_nxt.rdata = q_r.edge_rise;
      end
      if (i_req.addr == `PIA_OFS_EDGE_FALL) begin
        q_nxt.rdata = q_r.edge_fall;
      end
      if (i_req.addr == `PIA_OFS_IRQ_CTRL) begin
        q_nxt.rdata = q_r.ctrl;
      end
      if (i_req.addr == `PIA_OFS_OSC_THERMAL_CFG) begin
        q_nxt.rdata = q_r.cfg;
      end
    end
    // output line follows the flags of the same edge
    any_flag = |q_nxt.flags;
    line_on = any_flag && !(i_pwr_state == PIA_SLEEP &&
                            q_nxt.cfg[`PIA_CFG_MASK_SLEEP]);
    q_nxt.irq_line = ~(line_on ^ q_nxt.ctrl[`PIA_CTRL_POL_HI]);
    q_nxt.sleep_hold = any_flag;
    q_nxt.on_req = any_flag | wake_pulse;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_r <= RST_STATE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_rdata = q_r.rdata;
  assign o_irq_line = q_r.irq_line;
  assign o_on_req = q_r.on_req;
  assign o_sleep_hold = q_r.sleep_hold;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_flags_acc;
    acc && (i_req.addr < `PIA_OFS_EDGE_RISE) &&
    ((i_req.addr % `PIA_GRP_STRIDE) == `PIA_OFS_FLAGS);
  endsequence

  sequence s_same_acc;
    acc && (i_req.addr == $past(i_req.addr, 2));
  endsequence

  property p_block_no_set;
    ((q_nxt.flags & ~q_r.flags & q_r.block) == '0);
  endproperty
  a_block_no_set: assert property (p_block_no_set)
    else $error("blocked source set its flag");

  property p_flag_kept;
    ((q_r.flags & ~clr) & ~q_nxt.flags) == '0;
  endproperty
  a_flag_kept: assert property (p_flag_kept)
    else $error("flag dropped without a clear");

  property p_line_level;
    ($past(i_pwr_state) == PIA_ACTIVE) |->
      ((o_irq_line ^ q_r.ctrl[`PIA_CTRL_POL_HI]) == ~(|q_r.flags));
  endproperty
  a_line_level: assert property (p_line_level)
    else $error("line level disagrees with flags");

  property p_one_clear;
    s_flags_acc ##1 !acc ##1 s_same_acc |-> (clr == '0);
  endproperty
  a_one_clear: assert property (p_one_clear)
    else $error("second back-to-back access cleared");

  property p_read_clear;
    (i_req.rd && !same && !q_r.ctrl[`PIA_CTRL_CLR_WR] &&
     i_req.addr == `PIA_OFS_FLAGS) |=>
      ((q_r.flags[0] & ~$past(q_r.pend[0]) & ~$past(evt[0])) == 8'h00) &&
      ((q_r.flags[1] & ~$past(q_r.flags[1]) & ~$past(evt[1])) == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read did not clear its register only");

  property p_write_clear;
    (i_req.wr && !same && q_r.ctrl[`PIA_CTRL_CLR_WR] &&
     i_req.addr == `PIA_OFS_FLAGS + 8'd3 * `PIA_GRP_STRIDE) |=>
      ((q_r.flags[3] & $past(i_req.wdata) & ~$past(q_r.pend[3]) &
        ~$past(evt[3])) == 8'h00);
  endproperty
  a_write_clear: assert property (p_write_clear)
    else $error("written one did not clear");

  property p_pend_store;
    q_r.ctrl[`PIA_CTRL_PEND_EN] |=>
      ((q_r.pend & $past(rep_ev)) == $past(rep_ev));
  endproperty
  a_pend_store: assert property (p_pend_store)
    else $error("repeat event not held pending");

  property p_pend_off;
    !q_r.ctrl[`PIA_CTRL_PEND_EN] |=> (q_r.pend == '0);
  endproperty
  a_pend_off: assert property (p_pend_off)
    else $error("pending kept while disabled");

  property p_new_latch;
    1'b1 |=> ((q_r.flags & $past(evt)) == $past(evt));
  endproperty
  a_new_latch: assert property (p_new_latch)
    else $error("event not latched");

  property p_pend_reload;
    (pend_rel != '0) |=>
      ((q_r.flags & $past(pend_rel)) == $past(pend_rel)) ##1
      (o_sleep_hold == 1'b1);
  endproperty
  a_pend_reload: assert property (p_pend_reload)
    else $error("pending event not reloaded");

  property p_sleep_hold;
    (q_r.flags != '0) |-> o_sleep_hold && o_on_req;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("sleep not held with flags set");

  property p_off_quiet;
    (i_pwr_state == PIA_OFF) |->
      ((evt[0] & `PIA_G1_OFF_GATE) == 8'h00);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("gated source raised in OFF");

  property p_live_level;
    (i_req.rd && (i_req.addr == `PIA_OFS_LIVE)) |=>
      (o_rdata == $past(q_r.filt[0]));
  endproperty
  a_live_level: assert property (p_live_level)
    else $error("live register not the filtered level");

  property p_gpio_edge;
    ((edge_ev[3] & q_r.sync3[3] & ~q_r.edge_rise) |
     (edge_ev[3] & ~q_r.sync3[3] & ~q_r.edge_fall)) == 8'h00;
  endproperty
  a_gpio_edge: assert property (p_gpio_edge)
    else $error("pin edge taken while disabled");

  property p_idle_level;
    (q_r.flags == '0) |-> (o_irq_line == ~q_r.ctrl[`PIA_CTRL_POL_HI]);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle line level disagrees with polarity");

  property p_sleep_quiet;
    (($past(i_pwr_state) == PIA_SLEEP) && q_r.cfg[`PIA_CFG_MASK_SLEEP]) |->
      (o_irq_line == ~q_r.ctrl[`PIA_CTRL_POL_HI]);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("line active in masked sleep");

  property p_read_keeps;
    (i_req.rd && !i_req.wr && q_r.ctrl[`PIA_CTRL_CLR_WR]) |-> (clr == '0);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read cleared in write-clear mode");

  property p_wake_any;
    (|(edge_ev[0] & `PIA_G1_WAKE_ANY)) |=> o_on_req;
  endproperty
  a_wake_any: assert property (p_wake_any)
    else $error("key or remote edge raised no wake");

endmodule : pia_top

//--- verif/pia_host_model.sv
// host-side register access model for the interrupt aggregator
`timescale 1ns/1ps
module pia_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_irq_line,
  output pia_pkg::pia_req_type o_req
);
  import pia_pkg::*;

  initial o_req = '0;

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) o_req <= {1'b1, 1'b0, a, 8'h00};
    @(posedge i_clk) o_req <= '0;
    #1 d = i_rdata;
  endtask : rd

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk) o_req <= {1'b0, 1'b1, a, v};
    @(posedge i_clk) o_req <= '0;
  endtask : wr

  // clear-on-read sweep, repeated up to four times while the line stays low
  task clear_all();
    logic [7:0] d;
    for (int n = 0; n < 4 && i_irq_line === 1'b0; n++) begin
      for (int g = 0; g < 4; g++) begin
        rd(8'(3 * g), d);
      end
    end
  endtask : clear_all
endmodule : pia_host_model

//--- verif/test_pmic_interrupt_aggregator.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
module test_pmic_interrupt_aggregator;
  import pia_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] e;} pia_row_type;
  logic i_clk;
  logic i_rst_b;
  logic irq;
  logic on_req;
  logic hold;
  logic seen_on;
  logic [7:0] rdata;
  logic [7:0] d;
  pia_grp_type src;
  pia_pwr_type pwr;
  pia_req_type req;
  int miscompares;
  int comparisons;
  int cycles;
  pia_row_type rows [9] = '{{8'h00, 8'h00}, {8'h01, 8'h00},
    {8'h02, 8'h0E}, {8'h04, 8'h00}, {8'h0C, 8'h00}, {8'h0D, 8'h00},
    {8'h0E, 8'h02}, {8'h0F, 8'h00}, {8'h20, 8'hFF}};

  pia_top u_pia_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_src_line(src),
    .i_pwr_state(pwr), .i_req(req), .o_rdata(rdata), .o_irq_line(irq),
    .o_on_req(on_req), .o_sleep_hold(hold));
  pia_host_model u_pia_host_model (.i_clk(i_clk), .i_rdata(rdata),
    .i_irq_line(irq), .o_req(req));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task give_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  always @(posedge i_clk) if (on_req === 1'b1) seen_on <= 1'b1;

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // change one group's source levels, then let the synchroniser settle
  task ev(input int g, input logic [7:0] v);
    @(posedge i_clk) src[g] <= v;
    repeat (6) @(posedge i_clk);
  endtask : ev

  // write-clear group four after touching another address
  task clr9(input logic [7:0] v);
    u_pia_host_model.rd(8'h0E, d);
    u_pia_host_model.wr(8'h09, v);
    u_pia_host_model.rd(8'h09, d);
  endtask : clr9

  initial begin
    i_rst_b = 1'b0;
    src = '0;
    src[0] = 8'h0E;
    pwr = PIA_ACTIVE;
    seen_on = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk({7'h00, irq}, 8'h01);
    foreach (rows[i]) begin
      u_pia_host_model.rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    ev(0, 8'h4E);
    ev(1, 8'h01);
    u_pia_host_model.rd(8'h05, d);
    chk(d, 8'h01);
    u_pia_host_model.rd(8'h03, d);
    chk(d, 8'h01);
    u_pia_host_model.rd(8'h03, d);
    chk(d, 8'h00);
    chk({7'h00, irq}, 8'h00);
    u_pia_host_model.clear_all();
    chk({7'h00, irq}, 8'h01);
    u_pia_host_model.wr(8'h04, 8'h01);
    ev(1, 8'h00);
    ev(1, 8'h01);
    u_pia_host_model.rd(8'h03, d);
    chk(d, 8'h00);
    u_pia_host_model.wr(8'h0C, 8'hFF);
    u_pia_host_model.wr(8'h0E, 8'h03);
    ev(3, 8'h03);
    u_pia_host_model.rd(8'h09, d);
    chk(d, 8'h03);
    u_pia_host_model.rd(8'h0E, d);
    chk(d, 8'h03);
    u_pia_host_model.wr(8'h09, 8'h01);
    u_pia_host_model.rd(8'h09, d);
    chk(d, 8'h02);
    u_pia_host_model.wr(8'h09, 8'h02);
    u_pia_host_model.rd(8'h09, d);
    chk(d, 8'h02);
    ev(3, 8'h01);
    ev(3, 8'h03);
    clr9(8'h02);
    chk(d, 8'h02);
    chk({7'h00, irq}, 8'h00);
    clr9(8'h02);
    chk(d, 8'h00);
    chk({7'h00, irq}, 8'h01);
    u_pia_host_model.wr(8'h0E, 8'h01);
    ev(3, 8'h02);
    ev(3, 8'h03);
    ev(3, 8'h02);
    ev(3, 8'h03);
    clr9(8'h01);
    chk(d, 8'h00);
    u_pia_host_model.wr(8'h0D, 8'h02);
    ev(3, 8'h01);
    clr9(8'h00);
    chk(d, 8'h02);
    u_pia_host_model.wr(8'h0F, 8'h01);
    @(posedge i_clk) pwr <= PIA_SLEEP;
    ev(3, 8'h07);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, hold}, 8'h01);
    clr9(8'hFF);
    chk(d, 8'h00);
    chk({7'h00, hold}, 8'h00);
    @(posedge i_clk) pwr <= PIA_OFF;
    @(posedge i_clk) seen_on <= 1'b0;
    ev(0, 8'h46);
    chk({7'h00, seen_on}, 8'h01);
    u_pia_host_model.rd(8'h00, d);
    chk(d, 8'h00);
    @(posedge i_clk) pwr <= PIA_ACTIVE;
    u_pia_host_model.wr(8'h0E, 8'h05);
    @(posedge i_clk);
    chk({7'h00, irq}, 8'h00);
    give_verdict();
  end
endmodule : test_pmic_interrupt_aggregator
